// ==== verilog/qom_register_bank.sv ====
// qom_register_bank: input and holding registers of the quad output module
// What this block does
// - status bit 15 flags flash checksum error
// - status bit 13 shows default mode
// - status bit 0 flags watchdog timeout
// - current variant range code in bits 1:0
// - voltage variant range code in bits 1:0
// - channel status at input offsets 1-4
// - raw converter counts at offsets 5-8
// - node address 1 to 247, default 247
// - baud code selects bit rate, default 9600
// - parity code none, odd, even; default none
// - watchdog time zero disables the timer
// - timeout drive overrides alarm and direct
`timescale 1ns/1ps
`default_nettype none
module qom_register_bank #(
  parameter int CLK_HZ = qom_pkg::CLK_FREQ_HZ
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  req_valid,
  input  wire qom_pkg::qom_req_t     req,
  output logic                       rsp_valid,
  output qom_pkg::qom_rsp_t          rsp,
  input  wire logic                  flash_cksum_err,
  input  wire logic                  default_mode,
  input  wire qom_pkg::qom_chan_t [3:0] chan_in,
  input  wire logic [3:0][15:0]      direct_level,
  input  wire logic [3:0]            alarm_active,
  input  wire logic [3:0][15:0]      alarm_level,
  input  wire logic [3:0][15:0]      timeout_level,
  output logic [3:0][15:0]           chan_drive,
  output logic [7:0]                 node_address,
  output logic [1:0]                 parity_mode,
  output logic                       bit_tick,
  output logic                       wdog_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // timing

  localparam int WDOG_UNIT_CYCLES = CLK_HZ / 1000 * qom_pkg::WDOG_UNIT_MS;

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0] node_address_r;
  logic [15:0] bit_rate_r;
  logic [15:0] parity_r;
  logic [15:0] wdog_time_r;
  logic [15:0] next_node_address;
  logic [15:0] next_bit_rate;
  logic [15:0] next_parity;
  logic [15:0] next_wdog_time;

  logic        fault;
  logic        next_fault;
  logic        wdog_expired;

  logic        rsp_valid_r;
  logic        next_rsp_valid;
  logic [15:0] rsp_data_r;
  logic [15:0] next_rsp_data;
  logic [7:0]  rsp_exc_r;
  logic [7:0]  next_rsp_exc;

  logic [15:0] status_word;
  logic [15:0] in_data;
  logic        in_hit;
  logic [15:0] hr_data;
  logic        hr_hit;
  logic [15:0] in_index;

  ////////////////////////////////////////////////////////////////////////////
  // module status word

  always_comb begin
    status_word = 16'h0000; // unused bits 12:1 stay zero
    status_word[qom_pkg::ST_FLASH_ERR]  = flash_cksum_err;
    status_word[qom_pkg::ST_UNUSED]     = 1'b0;
    status_word[qom_pkg::ST_DEFAULT_MD] = default_mode;
    status_word[qom_pkg::ST_WDOG_FAULT] = fault;
  end

  ////////////////////////////////////////////////////////////////////////////
  // input register read decode

  always_comb begin
    in_data  = 16'h0000;
    in_hit   = 1'b1;
    in_index = 16'h0000;
    if (req.addr == qom_pkg::IN_MODULE_STATUS) begin
      in_data = status_word;
    end else if (req.addr < qom_pkg::IN_COUNT_BASE) begin
      // one layout for all four channels; range code read as is
      in_index = req.addr - qom_pkg::IN_RANGE_BASE;
      in_data  = {14'h0000, chan_in[in_index[1:0]].range};
    end else if (req.addr <= qom_pkg::IN_LAST) begin
      in_index = req.addr - qom_pkg::IN_COUNT_BASE;
      in_data  = chan_in[in_index[1:0]].count;
    end else begin
      in_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // holding register read decode

  always_comb begin
    hr_data = 16'h0000;
    hr_hit  = 1'b1;
    case (req.addr)
      qom_pkg::HR_NODE_ADDRESS: hr_data = node_address_r;
      qom_pkg::HR_BIT_RATE:     hr_data = bit_rate_r;
      qom_pkg::HR_PARITY:       hr_data = parity_r;
      qom_pkg::HR_WDOG_TIME:    hr_data = wdog_time_r;
      default:                  hr_hit  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // access handling: writes commit and the answer registers at the same request edge

  always_comb begin
    next_node_address = node_address_r;
    next_bit_rate     = bit_rate_r;
    next_parity       = parity_r;
    next_wdog_time    = wdog_time_r;
    next_rsp_valid    = req_valid;
    next_rsp_data     = 16'h0000;
    next_rsp_exc      = qom_pkg::EXC_NONE;
    if (req_valid) begin
      if (req.space == qom_pkg::SPACE_INPUT) begin
        if (req.write) begin
          next_rsp_exc = qom_pkg::EXC_FUNCTION;
        end else if (!in_hit) begin
          next_rsp_exc = qom_pkg::EXC_ADDRESS;
        end else begin
          next_rsp_data = in_data;
        end
      end else if (!hr_hit) begin
        next_rsp_exc = qom_pkg::EXC_ADDRESS;
      end else if (!req.write) begin
        next_rsp_data = hr_data;
      end else begin
        // a refused value leaves the register untouched
        next_rsp_data = req.wdata;
        case (req.addr)
          qom_pkg::HR_NODE_ADDRESS: begin
            if (req.wdata >= qom_pkg::NODE_ADDR_MIN &&
                req.wdata <= qom_pkg::NODE_ADDR_MAX) begin
              next_node_address = req.wdata;
            end else begin
              next_rsp_exc = qom_pkg::EXC_VALUE;
            end
          end
          qom_pkg::HR_BIT_RATE: begin
            if (req.wdata <= qom_pkg::BIT_RATE_MAX) begin
              next_bit_rate = req.wdata;
            end else begin
              next_rsp_exc = qom_pkg::EXC_VALUE;
            end
          end
          qom_pkg::HR_PARITY: begin
            if (req.wdata <= qom_pkg::PARITY_MAX) begin
              next_parity = req.wdata;
            end else begin
              next_rsp_exc = qom_pkg::EXC_VALUE;
            end
          end
          qom_pkg::HR_WDOG_TIME: begin
            next_wdog_time = req.wdata;
          end
          default: begin
            next_rsp_exc = qom_pkg::EXC_ADDRESS;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      node_address_r <= qom_pkg::NODE_ADDR_RESET;
      bit_rate_r     <= qom_pkg::BIT_RATE_RESET;
      parity_r       <= qom_pkg::PARITY_RESET;
      wdog_time_r    <= qom_pkg::WDOG_TIME_RESET;
      rsp_valid_r    <= 1'b0;
      rsp_data_r     <= 16'h0000;
      rsp_exc_r      <= qom_pkg::EXC_NONE;
    end else begin
      node_address_r <= next_node_address;
      bit_rate_r     <= next_bit_rate;
      parity_r       <= next_parity;
      wdog_time_r    <= next_wdog_time;
      rsp_valid_r    <= next_rsp_valid;
      rsp_data_r     <= next_rsp_data;
      rsp_exc_r      <= next_rsp_exc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: any access to this node kicks it and clears a pending fault

  qom_watchdog #(
    .UNIT_CYCLES (WDOG_UNIT_CYCLES)
  ) u_watchdog (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .limit   (wdog_time_r),
    .kick    (req_valid),
    .expired (wdog_expired)
  );

  // an expiry in the clearing cycle wins over the clear
  always_comb begin
    next_fault = fault;
    if (req_valid) begin
      next_fault = 1'b0;
    end
    if (wdog_expired) begin
      next_fault = 1'b1;
    end
    if (wdog_time_r == 16'h0000) begin
      next_fault = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive priority per channel

  logic [3:0][15:0] drive_r;
  logic [3:0][15:0] next_drive;

  for (genvar ch = 0; ch < qom_pkg::NUM_CHAN; ch++) begin : g_chan
    always_comb begin
      if (fault) begin
        next_drive[ch] = timeout_level[ch];
      end else if (alarm_active[ch]) begin
        next_drive[ch] = alarm_level[ch];
      end else begin
        next_drive[ch] = direct_level[ch];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive_r <= '0;
    end else begin
      drive_r <= next_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial link settings

  qom_bit_rate #(
    .CLK_HZ (CLK_HZ)
  ) u_bit_rate (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .code     (bit_rate_r[2:0]),
    .bit_tick (bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rsp_valid    = rsp_valid_r;
  assign rsp.data     = rsp_data_r;
  assign rsp.exc      = rsp_exc_r;
  assign chan_drive   = drive_r;
  assign node_address = node_address_r[7:0];
  assign parity_mode  = parity_r[1:0];
  assign wdog_fault   = fault;

endmodule
`default_nettype wire

// ==== verilog/qom_pkg.sv ====
// qom_pkg: shared constants and carrier types of the quad output register bank
package qom_pkg;

  // register spaces and counts
  localparam int          NUM_CHAN        = 4;
  localparam logic [15:0] IN_MODULE_STATUS = 16'h0000;
  localparam logic [15:0] IN_RANGE_BASE   = 16'h0001;
  localparam logic [15:0] IN_COUNT_BASE   = 16'h0005;
  localparam logic [15:0] IN_LAST         = 16'h0008;
  localparam logic [15:0] HR_NODE_ADDRESS = 16'h0000;
  localparam logic [15:0] HR_BIT_RATE     = 16'h0001;
  localparam logic [15:0] HR_PARITY       = 16'h0002;
  localparam logic [15:0] HR_WDOG_TIME    = 16'h0003;

  // module status field positions
  localparam int ST_FLASH_ERR   = 15;
  localparam int ST_UNUSED      = 14;
  localparam int ST_DEFAULT_MD  = 13;
  localparam int ST_WDOG_FAULT  = 0;

  // reset values and legal ranges
  localparam logic [15:0] NODE_ADDR_RESET = 16'h00f7;
  localparam logic [15:0] NODE_ADDR_MIN   = 16'h0001;
  localparam logic [15:0] NODE_ADDR_MAX   = 16'h00f7;
  localparam logic [15:0] BIT_RATE_RESET  = 16'h0002;
  localparam logic [15:0] BIT_RATE_MAX    = 16'h0006;
  localparam logic [15:0] PARITY_RESET    = 16'h0000;
  localparam logic [15:0] PARITY_MAX      = 16'h0002;
  localparam logic [15:0] WDOG_TIME_RESET = 16'h0000;

  // parity modes
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ODD  = 2'h1;
  localparam logic [1:0] PARITY_EVEN = 2'h2;

  // bit rates per code, in bits per second
  localparam int BAUD_0 = 2400;
  localparam int BAUD_1 = 4800;
  localparam int BAUD_2 = 9600;
  localparam int BAUD_3 = 14400;
  localparam int BAUD_4 = 19200;
  localparam int BAUD_5 = 28800;
  localparam int BAUD_6 = 38400;

  // clock and watchdog time unit
  localparam int CLK_FREQ_HZ  = 50_000_000;
  localparam int WDOG_UNIT_MS = 1;

  // exception codes returned with a refused access
  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_FUNCTION  = 8'h01;
  localparam logic [7:0] EXC_ADDRESS   = 8'h02;
  localparam logic [7:0] EXC_VALUE     = 8'h03;

  typedef enum logic {
    SPACE_INPUT,
    SPACE_HOLDING
  } qom_space_t;

  typedef struct packed {
    logic        write;
    qom_space_t  space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } qom_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0]  exc;
  } qom_rsp_t;

  typedef struct packed {
    logic [1:0]  range;
    logic [15:0] count;
  } qom_chan_t;

endpackage

// ==== verilog/qom_bit_rate.sv ====
// qom_bit_rate: one-cycle bit enable pulse at the rate that the baud code selects
`timescale 1ns/1ps
`default_nettype none
module qom_bit_rate #(
  parameter int CLK_HZ = qom_pkg::CLK_FREQ_HZ
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] code,
  output logic            bit_tick
);
  logic [15:0] div;
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  // nearest whole divisor
  always_comb begin
    case (code)
      3'h0:    div = 16'((CLK_HZ + qom_pkg::BAUD_0 / 2) / qom_pkg::BAUD_0);
      3'h1:    div = 16'((CLK_HZ + qom_pkg::BAUD_1 / 2) / qom_pkg::BAUD_1);
      3'h2:    div = 16'((CLK_HZ + qom_pkg::BAUD_2 / 2) / qom_pkg::BAUD_2);
      3'h3:    div = 16'((CLK_HZ + qom_pkg::BAUD_3 / 2) / qom_pkg::BAUD_3);
      3'h4:    div = 16'((CLK_HZ + qom_pkg::BAUD_4 / 2) / qom_pkg::BAUD_4);
      3'h5:    div = 16'((CLK_HZ + qom_pkg::BAUD_5 / 2) / qom_pkg::BAUD_5);
      3'h6:    div = 16'((CLK_HZ + qom_pkg::BAUD_6 / 2) / qom_pkg::BAUD_6);
      default: div = 16'((CLK_HZ + qom_pkg::BAUD_2 / 2) / qom_pkg::BAUD_2);
    endcase
  end

  // a code change restarts cleanly because cnt is compared with >=
  always_comb begin
    next_cnt = cnt + 16'h0001;
    bit_tick = 1'b0;
    if (cnt >= div - 16'h0001) begin
      next_cnt = 16'h0000;
      bit_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/qom_watchdog.sv ====
// qom_watchdog: unit prescaler and timeout counter of the output watchdog
`timescale 1ns/1ps
`default_nettype none
module qom_watchdog #(
  parameter int UNIT_CYCLES = 50_000
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] limit,
  input  wire logic        kick,
  output logic             expired
);
  logic [31:0] pre;
  logic [31:0] next_pre;
  logic [15:0] units;
  logic [15:0] next_units;
  logic        unit_tick;

  always_comb begin
    unit_tick  = (pre == 32'(UNIT_CYCLES - 1));
    next_pre   = unit_tick ? 32'h0000_0000 : pre + 32'h0000_0001;
    next_units = units;
    expired    = 1'b0;
    if (limit == 16'h0000 || kick) begin
      // zero time holds the timer off
      next_pre   = 32'h0000_0000;
      next_units = 16'h0000;
    end else if (unit_tick) begin
      if (units + 16'h0001 >= limit) begin
        expired    = 1'b1;
        next_units = 16'h0000;
      end else begin
        next_units = units + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pre   <= 32'h0000_0000;
      units <= 16'h0000;
    end else begin
      pre   <= next_pre;
      units <= next_units;
    end
  end
endmodule
`default_nettype wire

// ==== dv/qom_register_bank_asserts.sv ====
// qom_register_bank_asserts: port-level checks of the quad output register bank
`timescale 1ns/1ps
`default_nettype none
module qom_register_bank_asserts #(
  parameter int CLK_HZ = qom_pkg::CLK_FREQ_HZ
) (
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic                     req_valid,
  input wire qom_pkg::qom_req_t        req,
  input wire logic                     rsp_valid,
  input wire qom_pkg::qom_rsp_t        rsp,
  input wire logic                     flash_cksum_err,
  input wire logic                     default_mode,
  input wire qom_pkg::qom_chan_t [3:0] chan_in,
  input wire logic [3:0][15:0]         direct_level,
  input wire logic [3:0]               alarm_active,
  input wire logic [3:0][15:0]         alarm_level,
  input wire logic [3:0][15:0]         timeout_level,
  input wire logic [3:0][15:0]         chan_drive,
  input wire logic [7:0]               node_address,
  input wire logic [1:0]               parity_mode,
  input wire logic                     bit_tick,
  input wire logic                     wdog_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_in_rd;
    req_valid && !req.write && req.space == qom_pkg::SPACE_INPUT;
  endsequence
  sequence s_hr_wr;
    req_valid && req.write && req.space == qom_pkg::SPACE_HOLDING;
  endsequence
  AST_STATUS: assert property (s_in_rd ##0 req.addr == 16'h0000 |=>
    rsp.data[15:1] == {$past(flash_cksum_err), 1'b0, $past(default_mode), 12'h000})
    else $error("status word wrong");
  AST_RANGE: assert property (s_in_rd ##0 req.addr inside {[16'h0001:16'h0004]} |=>
    rsp.data == {14'h0000, $past(chan_in[req.addr[1:0] - 2'h1].range)})
    else $error("range status wrong");
  AST_COUNT: assert property (s_in_rd ##0 req.addr inside {[16'h0005:16'h0008]} |=>
    rsp.data == $past(chan_in[req.addr[1:0] - 2'h1].count)) else $error("count wrong");
  AST_IN_WR: assert property (req_valid && req.write && req.space == qom_pkg::SPACE_INPUT
    |=> rsp_valid && rsp.exc == qom_pkg::EXC_FUNCTION) else $error("input write taken");
  AST_ADDR_BAD: assert property (s_hr_wr ##0 req.addr == 16'h0000 &&
    (req.wdata == 16'h0000 || req.wdata > 16'h00f7) |=>
    rsp.exc == qom_pkg::EXC_VALUE && $stable(node_address)) else $error("bad address taken");
  AST_ADDR_OK: assert property (s_hr_wr ##0 req.addr == 16'h0000 &&
    req.wdata inside {[16'h0001:16'h00f7]} |=> node_address == $past(req.wdata[7:0]))
    else $error("address not stored");
  AST_PARITY: assert property (s_hr_wr ##0 req.addr == 16'h0002 |=> parity_mode ==
    ($past(req.wdata) > 16'h0002 ? $past(parity_mode) : $past(req.wdata[1:0])))
    else $error("parity mode wrong");
  AST_WDOG_OFF: assert property (s_hr_wr ##0 req.addr == 16'h0003 &&
    req.wdata == 16'h0000 |=> !wdog_fault [*8]) else $error("fault while disabled");
  AST_FAULT_FALL: assert property ($fell(wdog_fault) |-> $past(req_valid))
    else $error("fault cleared without access");
  AST_TO_DRIVE: assert property (wdog_fault |=> chan_drive == $past(timeout_level))
    else $error("timeout level not driven");
  AST_ALARM: assert property (!wdog_fault |=> chan_drive[0] ==
    ($past(alarm_active[0]) ? $past(alarm_level[0]) : $past(direct_level[0])))
    else $error("alarm or direct level wrong");
endmodule
bind qom_register_bank qom_register_bank_asserts #(.CLK_HZ(CLK_HZ)) u_chk (.ref_clk, .rst_n,
  .req_valid, .req, .rsp_valid, .rsp, .flash_cksum_err, .default_mode, .chan_in,
  .direct_level, .alarm_active, .alarm_level, .timeout_level, .chan_drive, .node_address,
  .parity_mode, .bit_tick, .wdog_fault);
`default_nettype wire

// ==== dv/qom_host_model.sv ====
// qom_host_model: bus host that issues one register access at a time
`timescale 1ns/1ps
`default_nettype none
module qom_host_model (
  input  wire logic              ref_clk,
  output logic                   req_valid,
  output qom_pkg::qom_req_t      req,
  input  wire logic              rsp_valid,
  input  wire qom_pkg::qom_rsp_t rsp
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  task automatic xfer(input logic w, input qom_pkg::qom_space_t sp, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] data, output logic [7:0] exc,
                      output logic ok);
    @(negedge ref_clk);
    req_valid = 1'b1;
    req = '{write: w, space: sp, addr: a, wdata: d};
    @(negedge ref_clk);
    // the answer strobe stands for one cycle only, so take it before letting go
    ok = rsp_valid;
    data = rsp.data;
    exc = rsp.exc;
    req_valid = 1'b0;
    // idle lines toggle so a stale request never looks valid by accident
    req = qom_pkg::qom_req_t'(~req);
  endtask
endmodule
`default_nettype wire

// ==== dv/quad_output_module_register_bank_tb.sv ====
// quad_output_module_register_bank_tb: self-checking bench of the register bank
`timescale 1ns/1ps
`default_nettype none
module quad_output_module_register_bank_tb;
  localparam int CLK = 100_000;
  localparam int UNIT = CLK / 1000;
  localparam qom_pkg::qom_space_t IN = qom_pkg::SPACE_INPUT;
  localparam qom_pkg::qom_space_t HR = qom_pkg::SPACE_HOLDING;
  localparam logic [15:0] HR_RST [4] = '{16'h00f7, 16'h0002, 16'h0000, 16'h0000};
  localparam int BAUD [7] = '{qom_pkg::BAUD_0, qom_pkg::BAUD_1, qom_pkg::BAUD_2,
    qom_pkg::BAUD_3, qom_pkg::BAUD_4, qom_pkg::BAUD_5, qom_pkg::BAUD_6};
  logic                     ref_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     req_valid;
  qom_pkg::qom_req_t        req;
  logic                     rsp_valid;
  qom_pkg::qom_rsp_t        rsp;
  logic                     flash_cksum_err = 1'b0;
  logic                     default_mode = 1'b0;
  qom_pkg::qom_chan_t [3:0] chan_in = '0;
  logic [3:0][15:0]         direct_level = {16'h1004, 16'h1003, 16'h1002, 16'h1001};
  logic [3:0]               alarm_active = 4'b0101;
  logic [3:0][15:0]         alarm_level = {16'ha004, 16'ha003, 16'ha002, 16'ha001};
  logic [3:0][15:0]         timeout_level = {16'h7004, 16'h7003, 16'h7002, 16'h7001};
  logic [3:0][15:0]         chan_drive;
  logic [7:0]               node_address;
  logic [1:0]               parity_mode;
  logic                     bit_tick;
  logic                     wdog_fault;
  int                       num_errors = 0;
  int                       cmp_count = 0;
  int                       cycles = 0;
  always #10 ref_clk = ~ref_clk;
  qom_host_model u_host (.ref_clk(ref_clk), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp));
  qom_register_bank #(.CLK_HZ(CLK)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .flash_cksum_err(flash_cksum_err), .default_mode(default_mode), .chan_in(chan_in),
    .direct_level(direct_level), .alarm_active(alarm_active), .alarm_level(alarm_level),
    .timeout_level(timeout_level), .chan_drive(chan_drive), .node_address(node_address),
    .parity_mode(parity_mode), .bit_tick(bit_tick), .wdog_fault(wdog_fault));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(input logic w, input qom_pkg::qom_space_t sp, input logic [15:0] a,
                     input logic [15:0] d, input logic [15:0] ed, input logic [7:0] ee);
    logic [15:0] data;
    logic [7:0]  exc;
    logic        ok;
    u_host.xfer(w, sp, a, d, data, exc, ok);
    check(ok, 1'b1);
    check(data, ed);
    check(exc, ee);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (bit_tick !== 1'b1 && n < 200);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(node_address, 8'hf7);
    check(parity_mode, 2'h0);
    for (int a = 0; a < 4; a++)
      acc(1'b0, HR, a[15:0], 16'h0000, HR_RST[a], 8'h00);
    acc(1'b0, HR, 16'h0004, 16'h0000, 16'h0000, qom_pkg::EXC_ADDRESS);
  endtask
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      flash_cksum_err = i[1];
      default_mode = i[0];
      acc(1'b0, IN, 16'h0000, 16'h0000, {i[1], 1'b0, i[0], 13'h0}, 8'h00);
    end
    flash_cksum_err = 1'b0;
    default_mode = 1'b0;
  endtask
  task automatic t_chan();
    for (int c = 0; c < 4; c++)
      chan_in[c] = '{range: c[1:0], count: 16'ha5c0 + c[15:0]};
    for (int a = 1; a <= 8; a++)
      acc(1'b0, IN, a[15:0], 16'h0000,
          a <= 4 ? {14'h0, 2'(a - 1)} : 16'ha5c0 + 16'(a - 5), 8'h00);
    acc(1'b0, IN, 16'h0009, 16'h0000, 16'h0000, qom_pkg::EXC_ADDRESS);
    acc(1'b1, IN, 16'h0005, 16'h1234, 16'h0000, qom_pkg::EXC_FUNCTION);
  endtask
  task automatic t_hold();
    acc(1'b1, HR, 16'h0000, 16'h0000, 16'h0000, qom_pkg::EXC_VALUE);
    acc(1'b1, HR, 16'h0000, 16'h00f8, 16'h00f8, qom_pkg::EXC_VALUE);
    check(node_address, 8'hf7);
    acc(1'b1, HR, 16'h0000, 16'h0001, 16'h0001, 8'h00);
    check(node_address, 8'h01);
    acc(1'b1, HR, 16'h0000, 16'h00f7, 16'h00f7, 8'h00);
    acc(1'b1, HR, 16'h0001, 16'h0007, 16'h0007, qom_pkg::EXC_VALUE);
    acc(1'b0, HR, 16'h0001, 16'h0000, 16'h0002, 8'h00);
    for (int p = 2; p >= 0; p--) begin
      acc(1'b1, HR, 16'h0002, p[15:0], p[15:0], 8'h00);
      check(parity_mode, p[1:0]);
    end
    acc(1'b1, HR, 16'h0002, 16'h0003, 16'h0003, qom_pkg::EXC_VALUE);
    check(parity_mode, 2'h0);
  endtask
  task automatic t_baud();
    int n;
    for (int c = 0; c < 7; c++) begin
      acc(1'b1, HR, 16'h0001, c[15:0], c[15:0], 8'h00);
      // the first tick after a code change may come early, so time the next one
      wait_tick(n);
      wait_tick(n);
      check(n, (CLK + BAUD[c] / 2) / BAUD[c]);
    end
  endtask
  task automatic t_wdog();
    int n;
    repeat (2) @(negedge ref_clk);
    check(chan_drive, {16'h1004, 16'ha003, 16'h1002, 16'ha001});
    acc(1'b1, HR, 16'h0003, 16'h0002, 16'h0002, 8'h00);
    repeat (4) begin
      repeat (UNIT) @(negedge ref_clk);
      check(wdog_fault, 1'b0);
      acc(1'b0, HR, 16'h0003, 16'h0000, 16'h0002, 8'h00);
    end
    n = 0;
    while (wdog_fault !== 1'b1 && n < 4 * UNIT) begin
      @(negedge ref_clk);
      n++;
    end
    check(n >= UNIT && n <= 3 * UNIT, 1'b1);
    @(negedge ref_clk);
    check(chan_drive, timeout_level);
    acc(1'b0, IN, 16'h0000, 16'h0000, 16'h0001, 8'h00);
    check(wdog_fault, 1'b0);
    acc(1'b1, HR, 16'h0003, 16'h0000, 16'h0000, 8'h00);
    repeat (4 * UNIT) @(negedge ref_clk);
    check(wdog_fault, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    do_reset();
    t_reset();
    t_status();
    t_chan();
    t_hold();
    t_baud();
    t_wdog();
    // a second reset in mid-run must bring back every holding value
    do_reset();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
